// ==== logic/brc_pkg.sv ====
// Shared constants and carrier types of the board reset controller.
`default_nettype none
package brc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing.
  localparam int CLK_MHZ = 25;
  // Least time the processor hard and peripheral resets are held asserted.
  localparam int T_HOLD_NS = 1000;
  localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  // Least time between peripheral release and processor release.
  localparam int T_PERIPH_NS = 400;
  localparam int PERIPH_CYC = (T_PERIPH_NS * CLK_MHZ + 999) / 1000;
  // Cycles that the configuration drive outlasts the processor reset.
  localparam int CFG_TAIL_CYC = 1;
  // Cycles an accepted request is held after its pin lets go.
  localparam int STRETCH_CYC = 8;
  localparam int CNT_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and reset values.
  localparam int SUB_W = 4;
  localparam int CFG_W = 8;
  localparam int AUX_W = 8;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
  localparam logic [AUX_W-1:0] AUX_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states.
  typedef enum logic [1:0] {
    BRC_IDLE,
    BRC_HOLD,
    BRC_PERIPH,
    BRC_CFG_TAIL
  } brc_state_t;

  // Reset requests, all active high.
  typedef struct packed {
    logic pg_low;
    logic sb_reset;
    logic trace_rec;
    logic cpu_req;
    logic dbg_hrst;
    logic wdog;
    logic dbg_trst;
  } brc_req_t;

  localparam int REQ_W = $bits(brc_req_t);

  // Reset outputs, all active high before inversion at the pins.
  typedef struct packed {
    logic proc_hrst;
    logic proc_trst;
    logic phy;
    logic lbus;
    logic mem;
    logic gen;
    logic config_drive_n;
  } brc_rst_t;

endpackage
`default_nettype wire

// ==== logic/brc_req_cond.sv ====
// Two-flop synchroniser and pulse stretcher for reset requests.
`timescale 1ns/1ns
`default_nettype none
module brc_req_cond #(
  parameter int W = 7,
  parameter int STRETCH = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Raw requests and conditioned requests.
  input wire logic [W-1:0] i_req,
  output logic [W-1:0] o_req
);

  // A stretch must fit the counter and cover a three-cycle pulse.
  if (STRETCH < 3 || STRETCH > 255) begin : g_bad_stretch
    $error("brc_req_cond: STRETCH out of range");
  end

  localparam logic [7:0] STRETCH_LD = 8'(STRETCH);

  ////////////////////////////////////////////////////////////////////////////
  // One synchroniser and stretcher per request bit.
  for (genvar b = 0; b < W; b++) begin : g_bit
    logic meta_reg;
    logic sync_reg;
    logic [7:0] cnt_reg;
    logic out_reg;

    // The first flop feeds only the second.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
      end else begin
        meta_reg <= i_req[b];
        sync_reg <= meta_reg;
      end
    end

    // A short pulse keeps the output up for STRETCH cycles more.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        cnt_reg <= 8'h00;
        out_reg <= 1'b0;
      end else begin
        if (sync_reg) begin
          cnt_reg <= STRETCH_LD;
        end else if (cnt_reg != 8'h00) begin
          cnt_reg <= cnt_reg - 8'h01;
        end
        out_reg <= sync_reg || (cnt_reg != 8'h00);
      end
    end

    assign o_req[b] = out_reg;
  end

endmodule // brc_req_cond
`default_nettype wire

// ==== logic/brc_top.sv ====
// Board reset controller: request gathering, reset terms and sequencer.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Main power-good low holds everything in reset.
// - Normal startup asserts processor test reset.
// - Debug hard reset never causes test reset.
// - No sequencer test reset with probe attached.
// - Debug hard reset resets whole board.
// - Stretch short processor reset request pulse.
// - Trace recovery resets by default, maskable.
// - Settings reset by all but subsupplies, start, debug test reset.
// - Aux register cleared only by power-level term.
// - Watchdog expiry clears all internal settings.
// - Debug hard reset clears all internal settings.
// - Subordinate supply changes reset no register.
// - Start, debug, general reset trigger sequencer.
// - Processor hard reset comes from sequencer only.
// - Test reset ORs sequencer and debug request.
// - Config drive outlasts processor reset one clock.
// - Software start keeps settings, runs startup.
// - Separate PHY, bus, memory, general resets.
// - Standby power reset resets controller completely.
module brc_top #(
  parameter int SUB_W = brc_pkg::SUB_W,
  parameter int CFG_W = brc_pkg::CFG_W,
  parameter int AUX_W = brc_pkg::AUX_W,
  parameter int STRETCH = brc_pkg::STRETCH_CYC
) (
  // Clock and standby power reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Power supply status.
  input wire logic i_main_power_good,
  input wire logic [SUB_W-1:0] i_sub_supply_good,
  // Debug port.
  input wire logic i_debug_hard_reset_n,
  input wire logic i_debug_test_reset_n,
  input wire logic i_debug_probe_attached,
  // Other reset sources.
  input wire logic i_southbridge_sw_reset_n,
  input wire logic i_trace_recovery_req_n,
  input wire logic i_trace_mask,
  input wire logic i_cpu_reset_request_n,
  input wire logic i_watchdog_expired,
  input wire logic i_sw_start,
  // Software configuration path.
  input wire logic i_cfg_we,
  input wire logic [CFG_W-1:0] i_cfg_wdata,
  // Reset outputs.
  output logic o_proc_hard_reset_n,
  output logic o_proc_test_reset_n,
  output logic o_phy_soft_reset_n,
  output logic o_local_bus_reset_n,
  output logic o_mem_reset_n,
  output logic o_general_hard_reset_n,
  output logic o_config_drive_n,
  // Status.
  output logic [CFG_W-1:0] o_settings,
  output logic [AUX_W-1:0] o_aux_count,
  output logic [SUB_W-1:0] o_sub_supply_status,
  output logic o_seq_busy
);

  // Widths that the logic cannot serve are refused here; the reset values
  // of the settings and of the tracking count are fixed-width constants.
  if (SUB_W < 1 || CFG_W != brc_pkg::CFG_W || AUX_W != brc_pkg::AUX_W) begin : g_bad_width
    $error("brc_top: unsupported width parameter");
  end

  // Every phase length must fit the phase counter, or a pass would
  // wrap and release the board far too early.
  if (brc_pkg::HOLD_CYC < 1 || brc_pkg::HOLD_CYC > (1 << brc_pkg::CNT_W) ||
      brc_pkg::PERIPH_CYC < 1 || brc_pkg::PERIPH_CYC > (1 << brc_pkg::CNT_W) ||
      brc_pkg::CFG_TAIL_CYC < 1 || brc_pkg::CFG_TAIL_CYC > (1 << brc_pkg::CNT_W)) begin : g_bad_timing
    $error("brc_top: phase length does not fit the counter");
  end

  localparam logic [brc_pkg::CNT_W-1:0] HOLD_LD =
    brc_pkg::CNT_W'(brc_pkg::HOLD_CYC - 1);
  localparam logic [brc_pkg::CNT_W-1:0] PERIPH_LD =
    brc_pkg::CNT_W'(brc_pkg::PERIPH_CYC - 1);
  localparam logic [brc_pkg::CNT_W-1:0] TAIL_LD =
    brc_pkg::CNT_W'(brc_pkg::CFG_TAIL_CYC - 1);
  localparam logic [AUX_W-1:0] AUX_ONE = AUX_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // Raw requests, turned active high.
  brc_pkg::brc_req_t raw_req;
  brc_pkg::brc_req_t cond_req;
  logic [brc_pkg::REQ_W-1:0] cond_bits;

  // Gather every source but the start command into one active-high carrier.
  always_comb begin
    raw_req.pg_low = !i_main_power_good;
    raw_req.sb_reset = !i_southbridge_sw_reset_n;
    raw_req.trace_rec = !i_trace_recovery_req_n && !i_trace_mask;
    raw_req.cpu_req = !i_cpu_reset_request_n;
    raw_req.dbg_hrst = !i_debug_hard_reset_n;
    raw_req.wdog = i_watchdog_expired;
    raw_req.dbg_trst = !i_debug_test_reset_n;
  end

  // Every request is synchronised and stretched before use.
  brc_req_cond #(
    .W(brc_pkg::REQ_W),
    .STRETCH(STRETCH)
  ) u_cond (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_req(raw_req),
    .o_req(cond_bits)
  );

  assign cond_req = cond_bits;

  ////////////////////////////////////////////////////////////////////////////
  // Reset terms.
  logic power_level_reset;
  logic extended_reset;
  logic sw_start_meta;
  logic sw_start_sync;
  logic sw_start_dly;
  logic go_pulse;

  // The power-level term covers supply, south bridge, trace and
  // processor requests; the extended term covers debug and watchdog.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      power_level_reset <= 1'b1;
      extended_reset <= 1'b0;
    end else begin
      power_level_reset <= cond_req.pg_low || cond_req.sb_reset ||
                           cond_req.trace_rec || cond_req.cpu_req;
      extended_reset <= cond_req.dbg_hrst || cond_req.wdog;
    end
  end

  // The start command is a level from software; only its rise counts.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sw_start_meta <= 1'b0;
      sw_start_sync <= 1'b0;
      sw_start_dly <= 1'b0;
    end else begin
      sw_start_meta <= i_sw_start;
      sw_start_sync <= sw_start_meta;
      sw_start_dly <= sw_start_sync;
    end
  end

  assign go_pulse = sw_start_sync && !sw_start_dly;

  ////////////////////////////////////////////////////////////////////////////
  // Internal registers.
  logic [CFG_W-1:0] settings_reg;
  logic [AUX_W-1:0] aux_tracking_reg;
  logic [SUB_W-1:0] sub_meta_reg;
  logic [SUB_W-1:0] sub_sync_reg;
  logic seq_done;

  // Settings clear on either term; the start command leaves them alone.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      settings_reg <= brc_pkg::CFG_RST;
    end else if (power_level_reset || extended_reset) begin
      settings_reg <= brc_pkg::CFG_RST;
    end else if (i_cfg_we) begin
      settings_reg <= i_cfg_wdata;
    end
  end

  // The tracking count survives debug and watchdog resets so that a
  // run of completed passes can be counted across them.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aux_tracking_reg <= brc_pkg::AUX_RST;
    end else if (power_level_reset) begin
      aux_tracking_reg <= brc_pkg::AUX_RST;
    end else if (seq_done) begin
      aux_tracking_reg <= aux_tracking_reg + AUX_ONE;
    end
  end

  // Subordinate supplies are only reported, never a reset source.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sub_meta_reg <= '0;
      sub_sync_reg <= '0;
    end else begin
      sub_meta_reg <= i_sub_supply_good;
      sub_sync_reg <= sub_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset sequencer.
  brc_pkg::brc_state_t state_reg;
  logic [brc_pkg::CNT_W-1:0] cnt_reg;
  logic skip_trst_reg;
  logic trigger;

  // Start, debug hard reset and the general reset all start a pass.
  assign trigger = power_level_reset || extended_reset || go_pulse;

  // A level trigger keeps the sequencer in its hold phase until it
  // lets go, so a long request is never released early.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= brc_pkg::BRC_HOLD;
      cnt_reg <= HOLD_LD;
    end else if (trigger) begin
      state_reg <= brc_pkg::BRC_HOLD;
      cnt_reg <= HOLD_LD;
    end else begin
      unique case (state_reg)
        brc_pkg::BRC_IDLE: begin
          cnt_reg <= cnt_reg;
        end
        brc_pkg::BRC_HOLD: begin
          if (cnt_reg == '0) begin
            state_reg <= brc_pkg::BRC_PERIPH;
            cnt_reg <= PERIPH_LD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        brc_pkg::BRC_PERIPH: begin
          if (cnt_reg == '0) begin
            state_reg <= brc_pkg::BRC_CFG_TAIL;
            cnt_reg <= TAIL_LD;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        brc_pkg::BRC_CFG_TAIL: begin
          if (cnt_reg == '0) begin
            state_reg <= brc_pkg::BRC_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  assign seq_done = !trigger && (state_reg == brc_pkg::BRC_CFG_TAIL) &&
                    (cnt_reg == '0);

  // A pass that a debug hard reset joins at any point skips the test
  // reset; a fresh pass from idle starts without the mark.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      skip_trst_reg <= 1'b0;
    end else if (trigger && state_reg == brc_pkg::BRC_IDLE) begin
      skip_trst_reg <= cond_req.dbg_hrst;
    end else if (cond_req.dbg_hrst) begin
      skip_trst_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops.
  brc_pkg::brc_rst_t rst_next;
  logic seq_trst;
  logic in_hold;
  logic in_proc;
  logic in_tail;

  assign in_hold = (state_reg == brc_pkg::BRC_HOLD);
  assign in_proc = in_hold || (state_reg == brc_pkg::BRC_PERIPH);
  assign in_tail = (state_reg == brc_pkg::BRC_CFG_TAIL);
  // The sequencer only drives the test reset when no probe owns it.
  assign seq_trst = in_hold && !skip_trst_reg &&
                    !i_debug_probe_attached;

  // Next level of every reset output, active high. The debug test reset
  // is ORed in after its synchroniser, so the debug port keeps direct
  // control of the test logic whatever the sequencer is doing.
  always_comb begin
    rst_next.proc_hrst = in_proc;
    rst_next.proc_trst = seq_trst || cond_req.dbg_trst;
    rst_next.phy = in_hold;
    rst_next.lbus = in_hold;
    rst_next.mem = in_hold;
    rst_next.gen = in_hold;
    rst_next.config_drive_n = in_proc || in_tail;
  end

  // Each pin is a flop of its own holding the active-low level, so no gate
  // can glitch a board reset net. All of them assert while standby reset is low.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_proc_hard_reset_n <= 1'b0;
      o_proc_test_reset_n <= 1'b0;
      o_phy_soft_reset_n <= 1'b0;
      o_local_bus_reset_n <= 1'b0;
      o_mem_reset_n <= 1'b0;
      o_general_hard_reset_n <= 1'b0;
      o_config_drive_n <= 1'b0;
    end else begin
      o_proc_hard_reset_n <= !rst_next.proc_hrst;
      o_proc_test_reset_n <= !rst_next.proc_trst;
      o_phy_soft_reset_n <= !rst_next.phy;
      o_local_bus_reset_n <= !rst_next.lbus;
      o_mem_reset_n <= !rst_next.mem;
      o_general_hard_reset_n <= !rst_next.gen;
      o_config_drive_n <= !rst_next.config_drive_n;
    end
  end

  // Settings and the tracking count are shown one cycle after they move.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_settings <= brc_pkg::CFG_RST;
      o_aux_count <= brc_pkg::AUX_RST;
    end else begin
      o_settings <= settings_reg;
      o_aux_count <= aux_tracking_reg;
    end
  end

  // Supply status is a report only; it feeds no reset term.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_sub_supply_status <= '0;
    end else begin
      o_sub_supply_status <= sub_sync_reg;
    end
  end

  // Busy reads high from power-up until the first pass has ended.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_seq_busy <= 1'b1;
    end else begin
      o_seq_busy <= (state_reg != brc_pkg::BRC_IDLE);
    end
  end

endmodule // brc_top
`default_nettype wire

// ==== verif/brc_src_model.sv ====
// Board-side reset sources: processor request pulser and main supply.
`timescale 1ns/1ns
`default_nettype none
module brc_src_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Bench commands.
  input wire logic i_cpu_fire,
  input wire logic i_cpu_len3,
  input wire logic i_switch_hold,
  // Source outputs.
  output logic o_cpu_reset_request_n,
  output var logic o_main_power_good
);
  logic fire_reg;
  logic [1:0] left_reg;
  // A request is only two or three cycles long, the hard case for the stretcher.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fire_reg <= 1'b0;
      left_reg <= 2'h0;
    end else begin
      fire_reg <= i_cpu_fire;
      if (i_cpu_fire && !fire_reg) begin
        left_reg <= i_cpu_len3 ? 2'h3 : 2'h2;
      end else if (left_reg != 2'h0) begin
        left_reg <= left_reg - 2'h1;
      end
    end
  end
  assign o_cpu_reset_request_n = (left_reg == 2'h0);
  // Power good stays low until the supply settles and while the switch is held.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_main_power_good <= 1'b0;
    end else begin
      o_main_power_good <= !i_switch_hold;
    end
  end
endmodule // brc_src_model
`default_nettype wire

// ==== verif/brc_top_assertions.sv ====
// Port-level assertions of the board reset controller.
`timescale 1ns/1ns
`default_nettype none
module brc_top_assertions #(
  parameter int CFG_W = 8
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Watched inputs.
  input wire logic i_main_power_good,
  input wire logic i_debug_hard_reset_n,
  input wire logic i_debug_test_reset_n,
  input wire logic i_debug_probe_attached,
  input wire logic i_cpu_reset_request_n,
  input wire logic i_watchdog_expired,
  input wire logic i_cfg_we,
  // Watched outputs.
  input wire logic o_proc_hard_reset_n,
  input wire logic o_proc_test_reset_n,
  input wire logic o_phy_soft_reset_n,
  input wire logic o_local_bus_reset_n,
  input wire logic o_mem_reset_n,
  input wire logic o_general_hard_reset_n,
  input wire logic o_config_drive_n,
  input wire logic [CFG_W-1:0] o_settings,
  input wire logic o_seq_busy
);
  localparam int GAP_LO = 9;
  localparam int GAP_HI = 11;
  logic [4:0] quiet_reg;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles of an attached probe with its test reset idle; saturates so it stays small.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      quiet_reg <= 5'h00;
    end else if (!i_debug_probe_attached || !i_debug_test_reset_n) begin
      quiet_reg <= 5'h00;
    end else if (quiet_reg != 5'h1F) begin
      quiet_reg <= quiet_reg + 5'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Output relations; a quiet span of 16 cycles covers sync and stretch latency.
  a_cfg_tail: assert property ($rose(o_proc_hard_reset_n) |-> !o_config_drive_n ##1 o_config_drive_n)
    else $error("config drive tail wrong");
  a_cfg_covers: assert property (!o_proc_hard_reset_n |-> !o_config_drive_n)
    else $error("config drive released early");
  a_periph_gap: assert property ($rose(o_phy_soft_reset_n) |-> ##[GAP_LO:GAP_HI] $rose(o_proc_hard_reset_n))
    else $error("processor release gap wrong");
  a_group_equal: assert property (o_phy_soft_reset_n == o_local_bus_reset_n &&
    o_mem_reset_n == o_general_hard_reset_n && o_phy_soft_reset_n == o_mem_reset_n)
    else $error("peripheral resets differ");
  a_busy_hrst: assert property (!o_proc_hard_reset_n |-> o_seq_busy)
    else $error("processor reset outside sequence");
  a_pg_reset: assert property (!i_main_power_good [*2] |-> ##[2:7] !o_phy_soft_reset_n)
    else $error("power good low ignored");
  a_cpu_stretch: assert property ($fell(i_cpu_reset_request_n) |-> ##[2:8] !o_proc_hard_reset_n [*8])
    else $error("processor request not stretched");
  a_trst_pass: assert property (!i_debug_test_reset_n |-> ##[1:5] !o_proc_test_reset_n)
    else $error("debug test reset not passed");
  a_probe_quiet: assert property (quiet_reg >= 5'h10 |-> o_proc_test_reset_n)
    else $error("test reset with probe attached");
  a_wdog_clear: assert property (i_watchdog_expired ##1 !i_cfg_we [*6] |-> o_settings == brc_pkg::CFG_RST)
    else $error("watchdog left settings");
  a_dbg_clear: assert property (!i_debug_hard_reset_n ##1 !i_cfg_we [*6] |-> o_settings == brc_pkg::CFG_RST)
    else $error("debug reset left settings");
  c_cpu_pass: cover property ($fell(i_cpu_reset_request_n) ##[2:8] !o_proc_hard_reset_n);
  c_dbg_pass: cover property (!i_debug_hard_reset_n ##[1:8] !o_phy_soft_reset_n);
  c_cfg_release: cover property ($rose(o_config_drive_n));
endmodule // brc_top_assertions
bind brc_top brc_top_assertions #(.CFG_W(CFG_W)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_main_power_good(i_main_power_good), .i_debug_hard_reset_n(i_debug_hard_reset_n),
  .i_debug_test_reset_n(i_debug_test_reset_n), .i_debug_probe_attached(i_debug_probe_attached),
  .i_cpu_reset_request_n(i_cpu_reset_request_n), .i_watchdog_expired(i_watchdog_expired), .i_cfg_we(i_cfg_we),
  .o_proc_hard_reset_n(o_proc_hard_reset_n), .o_proc_test_reset_n(o_proc_test_reset_n),
  .o_phy_soft_reset_n(o_phy_soft_reset_n), .o_local_bus_reset_n(o_local_bus_reset_n),
  .o_mem_reset_n(o_mem_reset_n), .o_general_hard_reset_n(o_general_hard_reset_n),
  .o_config_drive_n(o_config_drive_n), .o_settings(o_settings), .o_seq_busy(o_seq_busy));
`default_nettype wire

// ==== verif/brc_top_tb.sv ====
// Self-checking bench of the board reset controller.
`timescale 1ns/1ns
`default_nettype none
module brc_top_tb;
  logic i_clk, i_rst_b, pg, dbg_h_n, dbg_t_n, probe, sb_n, trc_n, trc_mask, cpu_n, wdog, start, cfg_we;
  logic cpu_fire, cpu_len3, sw_hold, trst_seen;
  logic hrst_n, trst_n, phy_n, lb_n, mem_n, gen_n, cfg_n, busy;
  logic [brc_pkg::SUB_W-1:0] sub, sub_st;
  logic [brc_pkg::CFG_W-1:0] cfg_d, settings;
  logic [brc_pkg::AUX_W-1:0] aux;
  logic [31:0] seed;
  int n_mismatch, n_checks, exp_s, exp_a;
  // Per source (start, cpu, debug, watchdog, bridge, trace, switch, reset): what it clears.
  int clr_s [8] = '{0, 1, 1, 1, 1, 1, 1, 1};
  int clr_a [8] = '{0, 1, 0, 0, 1, 1, 1, 1};
  ////////////////////////////////////////////////////////////////////////////
  brc_src_model src (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_cpu_fire(cpu_fire), .i_cpu_len3(cpu_len3),
    .i_switch_hold(sw_hold), .o_cpu_reset_request_n(cpu_n), .o_main_power_good(pg));
  brc_top uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_main_power_good(pg), .i_sub_supply_good(sub),
    .i_debug_hard_reset_n(dbg_h_n), .i_debug_test_reset_n(dbg_t_n), .i_debug_probe_attached(probe),
    .i_southbridge_sw_reset_n(sb_n), .i_trace_recovery_req_n(trc_n), .i_trace_mask(trc_mask),
    .i_cpu_reset_request_n(cpu_n), .i_watchdog_expired(wdog), .i_sw_start(start), .i_cfg_we(cfg_we),
    .i_cfg_wdata(cfg_d), .o_proc_hard_reset_n(hrst_n), .o_proc_test_reset_n(trst_n),
    .o_phy_soft_reset_n(phy_n), .o_local_bus_reset_n(lb_n), .o_mem_reset_n(mem_n),
    .o_general_hard_reset_n(gen_n), .o_config_drive_n(cfg_n), .o_settings(settings), .o_aux_count(aux),
    .o_sub_supply_status(sub_st), .o_seq_busy(busy));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz, and a record of any test reset seen during a pass.
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(negedge i_clk) if (trst_n === 1'b0) trst_seen = 1'b1;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // Bounded wait at falling edges, where outputs have settled.
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int t);
    t = 0;
    while (s !== v) begin
      @(negedge i_clk);
      t++;
      if (t > lim) begin
        check("wait", s, v);
        report_and_stop();
      end
    end
  endtask
  task automatic fire(input int k);
    @(posedge i_clk);
    case (k)
      0: start <= 1'b1;
      1: cpu_fire <= 1'b1;
      2: dbg_h_n <= 1'b0;
      3: wdog <= 1'b1;
      4: sb_n <= 1'b0;
      5: trc_n <= 1'b0;
      6: sw_hold <= 1'b1;
      default: ;
    endcase
    repeat (3) @(posedge i_clk);
    {start, cpu_fire, wdog, sw_hold} <= 4'h0;
    {dbg_h_n, sb_n, trc_n} <= 3'h7;
  endtask
  // One full pass: timing of the release order, test reset, then the settings model.
  task automatic run_pass(input int k, input logic trst_exp);
    int t;
    int lo;
    trst_seen = 1'b0;
    fire(k);
    wait_lvl(phy_n, 1'b0, 40, t);
    check("grp_on", {lb_n, mem_n, gen_n}, 3'h0);
    wait_lvl(phy_n, 1'b1, 300, lo);
    check("grp_off", {lb_n, mem_n, gen_n}, 3'h7);
    check("hold", lo >= brc_pkg::HOLD_CYC, 32'h1);
    wait_lvl(hrst_n, 1'b1, 40, t);
    check("periph", t, brc_pkg::PERIPH_CYC);
    wait_lvl(cfg_n, 1'b1, 10, t);
    check("cfg_tail", t, brc_pkg::CFG_TAIL_CYC);
    wait_lvl(busy, 1'b0, 10, t);
    @(negedge i_clk);
    check("trst", trst_seen, trst_exp);
    exp_s = clr_s[k] ? 0 : exp_s;
    exp_a = clr_a[k] ? 1 : (exp_a + 1) % 256;
    check("settings", settings, exp_s);
    check("aux", aux, exp_a);
  endtask
  task automatic write_cfg();
    seed = lfsr(seed);
    @(posedge i_clk);
    cfg_we <= 1'b1;
    cfg_d <= seed[7:0];
    cpu_len3 <= seed[8];
    @(posedge i_clk);
    cfg_we <= 1'b0;
    exp_s = seed[7:0];
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: every source once, mask, supplies, probe, then a standby reset while idle.
  initial begin
    {i_rst_b, probe, trc_mask, wdog, start, cfg_we, cpu_fire, cpu_len3, sw_hold} = 9'h000;
    {dbg_h_n, dbg_t_n, sb_n, trc_n} = 4'hF;
    sub = '1;
    cfg_d = 8'h00;
    seed = 32'h455D;
    n_mismatch = 0;
    n_checks = 0;
    exp_s = 0;
    exp_a = 0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    run_pass(7, 1'b1);
    for (int k = 0; k < 7; k++) begin
      write_cfg();
      run_pass(k, k != 2);
    end
    write_cfg();
    @(posedge i_clk);
    trc_mask <= 1'b1;
    fire(5);
    repeat (40) @(negedge i_clk);
    check("masked", busy, 1'b0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      @(posedge i_clk);
      sub <= seed[3:0];
      repeat (6) @(negedge i_clk);
      check("sub_status", sub_st, seed[3:0]);
      check("sub_busy", busy, 1'b0);
    end
    check("sub_aux", aux, exp_a);
    check("sub_settings", settings, exp_s);
    @(posedge i_clk);
    probe <= 1'b1;
    repeat (20) @(negedge i_clk);
    run_pass(3, 1'b0);
    @(posedge i_clk);
    dbg_t_n <= 1'b0;
    repeat (6) @(negedge i_clk);
    check("dbg_trst", trst_n, 1'b0);
    @(posedge i_clk);
    {dbg_t_n, probe} <= 2'h2;
    repeat (20) @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    run_pass(7, 1'b1);
    report_and_stop();
  end
endmodule // brc_top_tb
`default_nettype wire
